// ==== hw/bfw_pkg.sv ====
// package: register map, field layout and reset values of the forwarding window registers
package bfw_pkg;

  // ==========================================================================
  // byte offsets on the register bus
  localparam logic [7:0] BFW_IO_LOW_OFS    = 8'h1c;
  localparam logic [7:0] BFW_MEM_OFS       = 8'h20;
  localparam logic [7:0] BFW_PREF_OFS      = 8'h24;
  localparam logic [7:0] BFW_PREF_BOT_HI_OFS = 8'h28;
  localparam logic [7:0] BFW_PREF_TOP_HI_OFS = 8'h2c;
  localparam logic [7:0] BFW_IO_HI_OFS     = 8'h30;

  // ==========================================================================
  // field positions
  localparam int BFW_BOT_LSB     = 4;
  localparam int BFW_TOP_LSB     = 20;
  localparam int BFW_IO_BOT_LSB  = 4;
  localparam int BFW_IO_TOP_LSB  = 12;
  localparam int BFW_IO_CAP_BOT_LSB = 0;
  localparam int BFW_IO_CAP_TOP_LSB = 8;
  localparam int BFW_CAP_BOT_LSB = 0;
  localparam int BFW_CAP_TOP_LSB = 16;
  localparam int BFW_HALF_LSB    = 16;

  // ==========================================================================
  // capability codes and reset values
  localparam logic [3:0]  BFW_CAP_32     = 4'h0;
  localparam logic [3:0]  BFW_CAP_64     = 4'h1;
  localparam logic [3:0]  BFW_CAP_RST    = 4'h1;
  localparam logic [3:0]  BFW_IO_CAP     = 4'h1;
  localparam logic [11:0] BFW_WIN12_RST  = 12'h000;
  localparam logic [3:0]  BFW_NIB_RST    = 4'h0;
  localparam logic [15:0] BFW_HALF_RST   = 16'h0000;
  localparam logic [31:0] BFW_WORD_RST   = 32'h0000_0000;

  // ==========================================================================
  // low-order fill of expanded windows
  localparam logic [19:0] BFW_MEM_BOT_FILL = 20'h00000;
  localparam logic [19:0] BFW_MEM_TOP_FILL = 20'hfffff;
  localparam logic [11:0] BFW_IO_BOT_FILL  = 12'h000;
  localparam logic [11:0] BFW_IO_TOP_FILL  = 12'hfff;

  // transaction kinds presented to the window check
  typedef enum logic [1:0] {
    BFW_KIND_IO,
    BFW_KIND_MEM,
    BFW_KIND_NONE
  } bfw_kind_t;

endpackage : bfw_pkg

// ==== hw/bfw_range_cmp.sv ====
// range comparator: address within inclusive base and limit
`timescale 1ns/1ps
module bfw_range_cmp #(
  parameter int WIDTH = 64
) (
  // operands
  input  wire logic [WIDTH-1:0] addr,
  input  wire logic [WIDTH-1:0] bottom,
  input  wire logic [WIDTH-1:0] top,
  // result
  output logic                  hit
);
  assign hit = (addr >= bottom) && (addr <= top);
endmodule : bfw_range_cmp

// ==== hw/bfw_regs.sv ====
// forwarding window registers of a two-port bridge, apb slave, with address decode
// ============================================================================
// How it works
// - low four bits of memory base and limit fields read as zero
// - memory base bits are address 31:20 of window bottom, low bits zero
// - memory limit bits are address 31:20 of window top, low bits ones
// - memory transactions forward when address lies in memory window
// - prefetch fields carry addressing code in low nibble, reset 64-bit code
// - prefetch base bits 15:4 give address 31:20 of bottom, low zeros
// - prefetch limit bits 31:20 give address 31:20 of top, low ones
// - 32-bit word holds bits 63:32 of prefetch bottom, reset zero
// - 32-bit word holds bits 63:32 of prefetch top, reset zero
// - 16-bit field holds I/O bottom bits 31:16, reset zero
// - 16-bit field holds I/O top bits 31:16, reset zero
// - I/O bottom nibble gives address 15:12, low twelve bits zero
// - I/O top nibble gives address 15:12, low twelve bits ones
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module bfw_regs
  import bfw_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // transaction to check against the windows
  input  wire logic                 chk_valid,
  input  wire bfw_pkg::bfw_kind_t   chk_kind,
  input  wire logic                 chk_pref_64,
  input  wire logic [63:0]          chk_addr,
  // forwarding decision
  output logic                      fwd_valid,
  output logic                      fwd_hit,
  output logic                      fwd_mem_hit,
  output logic                      fwd_pref_hit,
  output logic                      fwd_io_hit
);

  // ==========================================================================
  // register state
  logic [11:0] mem_bot_r;
  logic [11:0] mem_top_r;
  logic [11:0] pref_bot_r;
  logic [11:0] pref_top_r;
  logic [3:0]  pref_cap_r;
  logic [31:0] pref_bot_hi_r;
  logic [31:0] pref_top_hi_r;
  logic [15:0] io_bot_hi_r;
  logic [15:0] io_top_hi_r;
  logic [3:0]  io_bot_nib_r;
  logic [3:0]  io_top_nib_r;

  // byte-lane merge of a write into a current word
  function automatic logic [31:0] bfw_merge(input logic [31:0] cur, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction : bfw_merge

  // ==========================================================================
  // bus decode
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_word;
  logic [31:0] mem_word;
  logic [31:0] pref_word;
  logic [31:0] io_lo_word;
  logic [31:0] io_hi_word;

  assign acc = psel && penable && !pready;
  // a write lands on the edge where the master sees pready, not one edge early
  assign wr  = psel && penable && pready && pwrite && mapped;

  // unwritten field bits come out of the merge untouched and are stored back unchanged
  always_comb
  begin
    mem_word = '0;
    mem_word[BFW_BOT_LSB +: 12] = mem_bot_r;
    mem_word[BFW_TOP_LSB +: 12] = mem_top_r;
    pref_word = '0;
    pref_word[BFW_CAP_BOT_LSB +: 4] = pref_cap_r;
    pref_word[BFW_CAP_TOP_LSB +: 4] = pref_cap_r;
    pref_word[BFW_BOT_LSB +: 12]    = pref_bot_r;
    pref_word[BFW_TOP_LSB +: 12]    = pref_top_r;
    io_lo_word = '0;
    io_lo_word[BFW_IO_CAP_BOT_LSB +: 4] = BFW_IO_CAP;
    io_lo_word[BFW_IO_CAP_TOP_LSB +: 4] = BFW_IO_CAP;
    io_lo_word[BFW_IO_BOT_LSB +: 4]     = io_bot_nib_r;
    io_lo_word[BFW_IO_TOP_LSB +: 4]     = io_top_nib_r;
    io_hi_word = {io_top_hi_r, io_bot_hi_r};
  end

  // ==========================================================================
  // write data merged into each word under the byte strobes
  logic [31:0] mem_merge;
  logic [31:0] pref_merge;
  logic [31:0] io_hi_merge;
  logic [31:0] io_lo_merge;

  assign mem_merge   = bfw_merge(mem_word, pwdata, pstrb);
  assign pref_merge  = bfw_merge(pref_word, pwdata, pstrb);
  assign io_hi_merge = bfw_merge(io_hi_word, pwdata, pstrb);
  assign io_lo_merge = bfw_merge(io_lo_word, pwdata, pstrb);

  always_comb
  begin
    mapped  = 1'b1;
    rd_word = '0;
    unique case (paddr)
      BFW_IO_LOW_OFS:      rd_word = io_lo_word;
      BFW_MEM_OFS:         rd_word = mem_word;
      BFW_PREF_OFS:        rd_word = pref_word;
      BFW_PREF_BOT_HI_OFS: rd_word = pref_bot_hi_r;
      BFW_PREF_TOP_HI_OFS: rd_word = pref_top_hi_r;
      BFW_IO_HI_OFS:       rd_word = io_hi_word;
      default:             mapped  = 1'b0;
    endcase
  end

  // ==========================================================================
  // apb answer: one wait state, ready pulses in the second access cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (clk_en)
    begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      prdata  <= (acc && !pwrite && mapped) ? rd_word : '0;
    end
  end

  // ==========================================================================
  // memory window fields; low nibbles are not stored so they always read zero
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      mem_bot_r <= BFW_WIN12_RST;
      mem_top_r <= BFW_WIN12_RST;
    end
    else if (clk_en && wr && paddr == BFW_MEM_OFS)
    begin
      mem_bot_r <= mem_merge[BFW_BOT_LSB +: 12];
      mem_top_r <= mem_merge[BFW_TOP_LSB +: 12];
    end
  end

  // ==========================================================================
  // prefetchable window fields and addressing code
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pref_bot_r <= BFW_WIN12_RST;
      pref_top_r <= BFW_WIN12_RST;
      pref_cap_r <= BFW_CAP_RST;
    end
    else if (clk_en && wr && paddr == BFW_PREF_OFS)
    begin
      pref_bot_r <= pref_merge[BFW_BOT_LSB +: 12];
      pref_top_r <= pref_merge[BFW_TOP_LSB +: 12];
    end
  end

  // ==========================================================================
  // prefetchable upper words
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pref_bot_hi_r <= BFW_WORD_RST;
      pref_top_hi_r <= BFW_WORD_RST;
    end
    else if (clk_en && wr)
    begin
      if (paddr == BFW_PREF_BOT_HI_OFS)
        pref_bot_hi_r <= bfw_merge(pref_bot_hi_r, pwdata, pstrb);
      if (paddr == BFW_PREF_TOP_HI_OFS)
        pref_top_hi_r <= bfw_merge(pref_top_hi_r, pwdata, pstrb);
    end
  end

  // ==========================================================================
  // I/O window fields
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      io_bot_hi_r  <= BFW_HALF_RST;
      io_top_hi_r  <= BFW_HALF_RST;
      io_bot_nib_r <= BFW_NIB_RST;
      io_top_nib_r <= BFW_NIB_RST;
    end
    else if (clk_en && wr)
    begin
      if (paddr == BFW_IO_HI_OFS)
      begin
        io_bot_hi_r <= io_hi_merge[0 +: 16];
        io_top_hi_r <= io_hi_merge[BFW_HALF_LSB +: 16];
      end
      if (paddr == BFW_IO_LOW_OFS)
      begin
        io_bot_nib_r <= io_lo_merge[BFW_IO_BOT_LSB +: 4];
        io_top_nib_r <= io_lo_merge[BFW_IO_TOP_LSB +: 4];
      end
    end
  end

  // ==========================================================================
  // expanded windows
  logic [63:0] mem_bot_x;
  logic [63:0] mem_top_x;
  logic [63:0] pref_bot_x;
  logic [63:0] pref_top_x;
  logic [63:0] io_bot_x;
  logic [63:0] io_top_x;
  logic [63:0] addr_eff;
  logic        in_mem;
  logic        in_pref;
  logic        in_io;

  assign mem_bot_x  = {32'h0000_0000, mem_bot_r, BFW_MEM_BOT_FILL};
  assign mem_top_x  = {32'h0000_0000, mem_top_r, BFW_MEM_TOP_FILL};
  // upper words only count when the window advertises 64-bit addressing
  assign pref_bot_x = {(pref_cap_r == BFW_CAP_64) ? pref_bot_hi_r : 32'h0000_0000,
                       pref_bot_r, BFW_MEM_BOT_FILL};
  assign pref_top_x = {(pref_cap_r == BFW_CAP_64) ? pref_top_hi_r : 32'h0000_0000,
                       pref_top_r, BFW_MEM_TOP_FILL};
  assign io_bot_x   = {32'h0000_0000, io_bot_hi_r, io_bot_nib_r, BFW_IO_BOT_FILL};
  assign io_top_x   = {32'h0000_0000, io_top_hi_r, io_top_nib_r, BFW_IO_TOP_FILL};
  // a single-address cycle carries no upper half
  assign addr_eff   = chk_pref_64 ? chk_addr : {32'h0000_0000, chk_addr[31:0]};

  bfw_range_cmp #(
    .WIDTH(64)
  ) u_mem (
    .addr   (addr_eff),
    .bottom (mem_bot_x),
    .top    (mem_top_x),
    .hit    (in_mem)
  );

  bfw_range_cmp #(
    .WIDTH(64)
  ) u_pref (
    .addr   (addr_eff),
    .bottom (pref_bot_x),
    .top    (pref_top_x),
    .hit    (in_pref)
  );

  bfw_range_cmp #(
    .WIDTH(64)
  ) u_io (
    .addr   (addr_eff),
    .bottom (io_bot_x),
    .top    (io_top_x),
    .hit    (in_io)
  );

  // ==========================================================================
  // registered forwarding decision, one cycle after the check request
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      fwd_valid    <= 1'b0;
      fwd_hit      <= 1'b0;
      fwd_mem_hit  <= 1'b0;
      fwd_pref_hit <= 1'b0;
      fwd_io_hit   <= 1'b0;
    end
    else if (clk_en)
    begin
      fwd_valid    <= chk_valid;
      fwd_mem_hit  <= chk_valid && chk_kind == BFW_KIND_MEM && in_mem;
      fwd_pref_hit <= chk_valid && chk_kind == BFW_KIND_MEM && in_pref;
      fwd_io_hit   <= chk_valid && chk_kind == BFW_KIND_IO && in_io;
      fwd_hit      <= chk_valid && ((chk_kind == BFW_KIND_MEM && (in_mem || in_pref)) ||
                                    (chk_kind == BFW_KIND_IO && in_io));
    end
  end

endmodule : bfw_regs

// ==== test/bfw_checker.sv ====
// assertions on the ports of the forwarding window register block
`timescale 1ns/1ps
module bfw_checker (
  // clock and reset
  input wire logic               clock,
  input wire logic               resetn,
  input wire logic               clk_en,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // window check
  input wire logic               chk_valid,
  input wire bfw_pkg::bfw_kind_t chk_kind,
  input wire logic               chk_pref_64,
  input wire logic [63:0]        chk_addr,
  input wire logic               fwd_valid,
  input wire logic               fwd_hit,
  input wire logic               fwd_mem_hit,
  input wire logic               fwd_pref_hit,
  input wire logic               fwd_io_hit
);
  import bfw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // completed good read, the only moment prdata means anything
  wire rd_ok = pready && !pwrite && !pslverr;
  // ==========================================================================
  // register reads and outputs after reset
  a_mem_zero_nib: assert property (rd_ok && paddr == BFW_MEM_OFS |-> !prdata[3:0] && !prdata[19:16])
    else $error("memory word fixed nibbles not zero");
  a_pref_code: assert property (rd_ok && paddr == BFW_PREF_OFS |-> prdata[3:0] == BFW_CAP_64 && prdata[19:16] == BFW_CAP_64)
    else $error("prefetch addressing code wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !pready && !fwd_valid && prdata == 32'h0)
    else $error("outputs busy after reset");
  // ==========================================================================
  // forwarding decision
  a_check_answer: assert property (clk_en && chk_valid |=> fwd_valid)
    else $error("no decision one cycle after check");
  a_no_spurious: assert property (clk_en && !chk_valid |=> !fwd_valid && !fwd_hit)
    else $error("decision without a check");
  a_mem_kind: assert property (fwd_mem_hit || fwd_pref_hit |-> fwd_valid && $past(chk_kind) == BFW_KIND_MEM)
    else $error("memory hit for non-memory kind");
  a_io_kind: assert property (fwd_io_hit |-> fwd_valid && $past(chk_kind) == BFW_KIND_IO)
    else $error("io hit for non-io kind");
  a_hit_union: assert property (fwd_valid |-> fwd_hit == (fwd_mem_hit || fwd_pref_hit || fwd_io_hit))
    else $error("overall hit disagrees with window hits");
  c_write: cover property (pready && pwrite);
  c_refused: cover property (pready && pslverr);
  c_pref: cover property (fwd_pref_hit);
  c_io: cover property (fwd_io_hit);
endmodule : bfw_checker

// ==== test/bfw_agent.sv ====
// far-side bus agent presenting transactions to the window check
`timescale 1ns/1ps
module bfw_agent (
  // clock
  input wire logic           clock,
  // transaction to check
  output logic               chk_valid,
  output bfw_pkg::bfw_kind_t chk_kind,
  output logic               chk_pref_64,
  output logic [63:0]        chk_addr
);
  import bfw_pkg::*;
  initial
  begin
    chk_valid = 1'b0;
    chk_kind = BFW_KIND_NONE;
    chk_pref_64 = 1'b0;
    chk_addr = 64'h0;
  end
  task automatic issue(input bfw_kind_t k, input logic p64, input logic [63:0] a);
    @(posedge clock);
    chk_valid <= 1'b1;
    chk_kind <= k;
    chk_pref_64 <= p64;
    chk_addr <= a;
    @(posedge clock);
    chk_valid <= 1'b0;
    chk_kind <= BFW_KIND_NONE;
    // idle address flips so a stale value is never taken for a live one
    chk_addr <= ~a;
  endtask : issue
endmodule : bfw_agent

// ==== test/tb.sv ====
// self-checking bench for the forwarding window registers
`timescale 1ns/1ps
module tb;
  import bfw_pkg::*;
  logic        clock, resetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [3:0]  strb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] chk_addr;
  bfw_kind_t   chk_kind;
  logic        chk_valid, chk_pref_64, fwd_valid, fwd_hit, fwd_mem_hit, fwd_pref_hit, fwd_io_hit;
  int          err_count, samples_checked;

  bfw_regs bfw_regs_i (.clock(clock), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chk_valid(chk_valid), .chk_kind(chk_kind), .chk_pref_64(chk_pref_64),
    .chk_addr(chk_addr), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_mem_hit(fwd_mem_hit),
    .fwd_pref_hit(fwd_pref_hit), .fwd_io_hit(fwd_io_hit));
  bfw_agent bfw_agent_i (.clock(clock), .chk_valid(chk_valid), .chk_kind(chk_kind),
    .chk_pref_64(chk_pref_64), .chk_addr(chk_addr));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ==========================================================================
  // compare and bus tasks
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp1
  task automatic final_report;
    $display("Checks: %0d, errors: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("Error at %0t: no pready", $time);
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp32(rd, exp);
  endtask : rdc
  // e holds the expected memory, prefetch and io hits
  task automatic chk(input bfw_kind_t k, input logic p64, input logic [63:0] a, input logic [2:0] e);
    bfw_agent_i.issue(k, p64, a);
    @(posedge clock);
    cmp1(fwd_valid, 1'b1);
    cmp1(fwd_mem_hit, e[2]);
    cmp1(fwd_pref_hit, e[1]);
    cmp1(fwd_io_hit, e[0]);
    cmp1(fwd_hit, |e);
  endtask : chk
  // ==========================================================================
  // main sequence
  initial
  begin
    resetn = 1'b0;
    clk_en = 1'b1;
    strb = 4'hf;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rdc(BFW_MEM_OFS, 32'h0);
    rdc(BFW_PREF_OFS, 32'h0001_0001);
    rdc(BFW_PREF_BOT_HI_OFS, 32'h0);
    rdc(BFW_PREF_TOP_HI_OFS, 32'h0);
    rdc(BFW_IO_HI_OFS, 32'h0);
    rdc(BFW_IO_LOW_OFS, 32'h0000_0101);
    chk(BFW_KIND_MEM, 1'b0, 64'h0, 3'b110);
    apb(1'b1, BFW_MEM_OFS, 32'hffff_ffff);
    rdc(BFW_MEM_OFS, 32'hfff0_fff0);
    apb(1'b1, 8'h40, 32'h1);
    cmp1(err, 1'b1);
    // only byte lane one may land
    strb <= 4'h2;
    apb(1'b1, BFW_PREF_BOT_HI_OFS, 32'hffff_ffff);
    rdc(BFW_PREF_BOT_HI_OFS, 32'h0000_ff00);
    strb <= 4'hf;
    apb(1'b1, BFW_MEM_OFS, 32'h1240_1230);
    apb(1'b1, BFW_PREF_OFS, 32'h2000_1ff0);
    apb(1'b1, BFW_PREF_BOT_HI_OFS, 32'h1);
    apb(1'b1, BFW_PREF_TOP_HI_OFS, 32'h1);
    apb(1'b1, BFW_IO_HI_OFS, 32'h0002_0001);
    apb(1'b1, BFW_IO_LOW_OFS, 32'h0000_8040);
    rdc(BFW_PREF_OFS, 32'h2001_1ff1);
    rdc(BFW_PREF_TOP_HI_OFS, 32'h1);
    rdc(BFW_IO_HI_OFS, 32'h0002_0001);
    rdc(BFW_IO_LOW_OFS, 32'h0000_8141);
    chk(BFW_KIND_MEM, 1'b0, 64'h1230_0000, 3'b100);
    chk(BFW_KIND_MEM, 1'b0, 64'h122f_ffff, 3'b000);
    chk(BFW_KIND_MEM, 1'b0, 64'h124f_ffff, 3'b100);
    chk(BFW_KIND_MEM, 1'b0, 64'h1250_0000, 3'b000);
    chk(BFW_KIND_MEM, 1'b1, 64'h1_1ff0_0000, 3'b010);
    chk(BFW_KIND_MEM, 1'b1, 64'h1_200f_ffff, 3'b010);
    chk(BFW_KIND_MEM, 1'b1, 64'h1_2010_0000, 3'b000);
    chk(BFW_KIND_MEM, 1'b1, 64'h0_2000_0000, 3'b000);
    chk(BFW_KIND_IO, 1'b0, 64'h0001_4000, 3'b001);
    chk(BFW_KIND_IO, 1'b0, 64'h0001_3fff, 3'b000);
    chk(BFW_KIND_IO, 1'b0, 64'h0002_8fff, 3'b001);
    chk(BFW_KIND_IO, 1'b0, 64'h0002_9000, 3'b000);
    chk(BFW_KIND_NONE, 1'b0, 64'h1230_0000, 3'b000);
    // with the clock enable low a check must not reach the decision
    @(posedge clock);
    clk_en <= 1'b0;
    bfw_agent_i.issue(BFW_KIND_MEM, 1'b0, 64'h1230_0000);
    @(posedge clock);
    cmp1(fwd_valid, 1'b0);
    clk_en <= 1'b1;
    final_report();
  end
endmodule : tb

bind bfw_regs bfw_checker bfw_checker_i (.clock(clock), .resetn(resetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .chk_valid(chk_valid), .chk_kind(chk_kind), .chk_pref_64(chk_pref_64),
  .chk_addr(chk_addr), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_mem_hit(fwd_mem_hit),
  .fwd_pref_hit(fwd_pref_hit), .fwd_io_hit(fwd_io_hit));
